// ===== tb/bus_memory_model.sv
module bus_memory_model (
  input wire logic clk_i,
  input wire logic [23:0] bus_addr_i,
  input wire logic bus_rd_i,
  input wire logic bus_wr_i,
  input wire logic [1:0] bus_be_i,
  input wire logic [15:0] bus_wdata_i,
  output logic [15:0] bus_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [int];
  logic [15:0] last = 16'h0000;
  logic [23:0] ev;
  function automatic logic [7:0] rb(input logic [23:0] a);
    if (mem.exists(int'(a))) return mem[int'(a)];
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction : rb
  assign ev = {bus_addr_i[23:1], 1'b0};
  // written lanes are kept and read back later
  always @(posedge clk_i) begin
    if (bus_wr_i && bus_be_i[0]) mem[int'(ev)] = bus_wdata_i[7:0];
    if (bus_wr_i && bus_be_i[1]) mem[int'(ev) + 1] = bus_wdata_i[15:8];
    if (bus_rd_i) last <= bus_rdata_o;
  end
  // a released bus shows the inverse of the last value
  always @(*) begin
    if (bus_rd_i) bus_rdata_o = {rb(ev + 24'h1), rb(ev)};
    else bus_rdata_o = ~last;
  end
endmodule : bus_memory_model

// ===== tb/prefetch_bus_interface_test.sv
module prefetch_bus_interface_test
  import gateway_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, nrst_i = 0, narrow_bus_i = 0, take_i = 0, jump_i = 0, rel_jump_i = 0;
  logic data_req_i = 0, data_we_i = 0, data_length_flag_i = 0, index_length_flag_i = 0;
  logic use_index_i = 0;
  logic [1:0] take_count_i = 2'h1, addr_mode_i = 2'h0;
  logic [23:0] jump_target_i = 24'h000000;
  logic [15:0] rel_offset_i = 16'h0000, data_offset_i = 16'h0000, data_wdata_i = 16'h0000;
  logic [15:0] zero_page_base_i = 16'h0000, bus_rdata_i;
  logic [7:0] data_bank_select_i = 8'h00;
  logic cpu_run_o, bus_rd_o, bus_wr_o, bus_internal_o, stack_bank_sel_o, ram_area_sel_o;
  logic [1:0] queue_count_o, bus_be_o;
  logic [23:0] queue_bytes_o, bus_addr_o;
  logic [7:0] code_bank_register_o;
  logic [15:0] program_counter_o, data_rdata_o, bus_wdata_o;
  int failures = 0, check_count = 0;
  logic [44:0] log_q [$];
  logic [44:0] prev = '0, cur;

  prefetch_bus_interface dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .narrow_bus_i(narrow_bus_i), .take_i(take_i),
    .take_count_i(take_count_i), .jump_i(jump_i), .jump_target_i(jump_target_i),
    .rel_jump_i(rel_jump_i), .rel_offset_i(rel_offset_i), .data_req_i(data_req_i),
    .data_we_i(data_we_i), .addr_mode_i(addr_mode_i), .data_offset_i(data_offset_i),
    .data_wdata_i(data_wdata_i), .data_length_flag_i(data_length_flag_i),
    .index_length_flag_i(index_length_flag_i), .use_index_i(use_index_i),
    .data_bank_select_i(data_bank_select_i), .zero_page_base_i(zero_page_base_i),
    .bus_rdata_i(bus_rdata_i), .cpu_run_o(cpu_run_o), .queue_bytes_o(queue_bytes_o),
    .queue_count_o(queue_count_o), .code_bank_register_o(code_bank_register_o),
    .program_counter_o(program_counter_o), .data_rdata_o(data_rdata_o),
    .bus_addr_o(bus_addr_o), .bus_rd_o(bus_rd_o), .bus_wr_o(bus_wr_o), .bus_be_o(bus_be_o),
    .bus_wdata_o(bus_wdata_o), .bus_internal_o(bus_internal_o),
    .stack_bank_sel_o(stack_bank_sel_o), .ram_area_sel_o(ram_area_sel_o)
  );
  bus_memory_model mem_u (
    .clk_i(clk_i), .bus_addr_i(bus_addr_o), .bus_rd_i(bus_rd_o), .bus_wr_i(bus_wr_o),
    .bus_be_i(bus_be_o), .bus_wdata_i(bus_wdata_o), .bus_rdata_o(bus_rdata_i)
  );

  always #50 clk_i = ~clk_i;

  // log of bus cycles: {internal, rd, wr, be, addr, wdata}
  always begin
    @(posedge clk_i);
    #20;
    cur = {bus_internal_o, bus_rd_o, bus_wr_o, bus_be_o, bus_addr_o, bus_wdata_o};
    if ((bus_rd_o || bus_wr_o) && cur !== prev) log_q.push_back(cur);
    prev = cur;
  end

  function automatic logic [7:0] mb(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction : mb

  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  // hold the request until the core clock runs, then let that edge take it
  task automatic hold_run(output bit first);
    int i;
    first = 1;
    #10;
    for (i = 0; i < 200 && cpu_run_o !== 1'b1; i++) begin
      first = 0;
      @(negedge clk_i);
      #10;
    end
    chk("core_run", 1, cpu_run_o);
    @(negedge clk_i);
  endtask : hold_run

  task automatic settle(input logic [1:0] n);
    int i;
    for (i = 0; i < 300 && queue_count_o !== n; i++) @(negedge clk_i);
    chk("settle", n, queue_count_o);
    cyc(4);
  endtask : settle

  task automatic jump(input logic [23:0] t);
    bit f;
    @(negedge clk_i);
    log_q.delete();
    jump_target_i = t;
    jump_i = 1;
    hold_run(f);
    jump_i = 0;
  endtask : jump

  task automatic take(input logic [1:0] n, output bit f);
    @(negedge clk_i);
    take_i = 1;
    take_count_i = n;
    hold_run(f);
    take_i = 0;
  endtask : take

  task automatic dop(input bit now, input bit we, input logic [1:0] m, input logic [7:0] bk,
                     input logic [15:0] off, input logic [15:0] wd, input bit byt, output bit f);
    if (!now) begin
      @(negedge clk_i);
      log_q.delete();
    end
    data_req_i = 1;
    data_we_i = we;
    addr_mode_i = m;
    data_bank_select_i = bk;
    data_offset_i = off;
    data_wdata_i = wd;
    data_length_flag_i = byt;
    hold_run(f);
    data_req_i = 0;
    cyc(6);
  endtask : dop

  task automatic rel(input logic [15:0] off);
    bit f;
    @(negedge clk_i);
    rel_offset_i = off;
    rel_jump_i = 1;
    hold_run(f);
    rel_jump_i = 0;
  endtask : rel

  task automatic t_fetch();
    bit f;
    jump(24'h123456);
    settle(2);
    chk("f_addr", 24'h123456, log_q[0][39:16]);
    chk("f_be", 2'h3, log_q[0][41:40]);
    chk("f_n", 1, log_q.size());
    chk("bank", 8'h12, code_bank_register_o);
    take(2'h1, f);
    settle(3);
    chk("q3", {mb(24'h123459), mb(24'h123458), mb(24'h123457)}, queue_bytes_o);
    chk("pc", 16'h3457, program_counter_o);
    cyc(8);
    chk("full", 2'h3, queue_count_o);
  endtask : t_fetch

  task automatic t_odd_narrow();
    jump(24'h123457);
    settle(3);
    chk("o_a0", 24'h123457, log_q[0][39:16]);
    chk("o_a1", 24'h123458, log_q[1][39:16]);
    chk("o_q", {mb(24'h123459), mb(24'h123458), mb(24'h123457)}, queue_bytes_o);
    narrow_bus_i = 1;
    jump(24'h120000);
    settle(2);
    chk("n_a1", 24'h120001, log_q[1][39:16]);
    chk("n_q", {mb(24'h120001), mb(24'h120000)}, queue_bytes_o[15:0]);
    narrow_bus_i = 0;
  endtask : t_odd_narrow

  task automatic t_stall_rel();
    bit f;
    jump(24'h124000);
    take(2'h3, f);
    chk("stall", 0, f);
    chk("s_pc", 16'h4003, program_counter_o);
    jump(24'h12FFF0);
    settle(2);
    rel(16'h0020);
    chk("up_bank", 8'h13, code_bank_register_o);
    chk("up_pc", 16'h0010, program_counter_o);
    rel(16'hFFC0);
    chk("dn_bank", 8'h12, code_bank_register_o);
    chk("dn_pc", 16'hFFD0, program_counter_o);
    settle(2);
  endtask : t_stall_rel

  task automatic t_reads();
    bit f;
    dop(0, 0, 2'h0, 8'h34, 16'h1000, 16'h0000, 0, f);
    chk("w_n", 1, log_q.size());
    chk("w_a", 24'h341000, log_q[0][39:16]);
    chk("w_be", 2'h3, log_q[0][41:40]);
    chk("w_d", {mb(24'h341001), mb(24'h341000)}, data_rdata_o);
    dop(0, 0, 2'h0, 8'h34, 16'h1001, 16'h0000, 0, f);
    chk("s_a0", 24'h341001, log_q[0][39:16]);
    chk("s_be0", 2'h2, log_q[0][41:40]);
    chk("s_a1", 24'h341002, log_q[1][39:16]);
    chk("s_be1", 2'h1, log_q[1][41:40]);
    chk("s_d", {mb(24'h341002), mb(24'h341001)}, data_rdata_o);
    use_index_i = 1;
    index_length_flag_i = 1;
    dop(0, 0, 2'h0, 8'h34, 16'h1003, 16'h0000, 0, f);
    chk("b_be", 2'h2, log_q[0][41:40]);
    chk("b_d", {8'h00, mb(24'h341003)}, data_rdata_o);
    use_index_i = 0;
    index_length_flag_i = 0;
    zero_page_base_i = 16'h2100;
    dop(0, 0, 2'(MODE_DIRECT), 8'h34, 16'h0010, 16'h0000, 1, f);
    chk("d_a", 24'h002110, log_q[0][39:16]);
    chk("d_be", 2'h1, log_q[0][41:40]);
    chk("d_d", {8'h00, mb(24'h002110)}, data_rdata_o);
  endtask : t_reads

  task automatic t_writes();
    bit f;
    dop(0, 1, 2'h0, 8'h34, 16'h1004, 16'hBEEF, 0, f);
    chk("p_run", 1, f);
    chk("p_wr", {1'b1, 2'h3, 24'h341004, 16'hBEEF}, log_q[0][42:0]);
    dop(0, 0, 2'h0, 8'h34, 16'h1004, 16'h0000, 0, f);
    chk("p_back", 16'hBEEF, data_rdata_o);
    dop(0, 1, 2'h0, 8'h00, 16'h0300, 16'h1111, 0, f);
    chk("r_off", 0, log_q[0][44]);
    dop(0, 1, 2'h0, 8'h00, 16'h005E, 16'h0280, 0, f);
    chk("m_int", 1, log_q[0][44]);
    chk("m_stk", 1, stack_bank_sel_o);
    chk("m_ram", 1, ram_area_sel_o);
    dop(0, 1, 2'h0, 8'h00, 16'h0300, 16'h1234, 0, f);
    chk("r_on", 3'h5, log_q[0][44:42]);
    dop(0, 0, 2'h0, 8'h00, 16'h0300, 16'h0000, 0, f);
    chk("r_rd", 16'h1234, data_rdata_o);
    dop(0, 0, 2'(MODE_STACK), 8'h34, 16'h0200, 16'h0000, 1, f);
    chk("stk_a", 24'hFF0200, log_q[0][39:16]);
  endtask : t_writes

  task automatic t_wait();
    bit f;
    int i;
    jump(24'h125001);
    for (i = 0; i < 50 && bus_rd_o !== 1'b1; i++) @(negedge clk_i);
    dop(1, 1, 2'h0, 8'h34, 16'h1006, 16'h5555, 0, f);
    settle(3);
    chk("busy", 0, f);
    chk("g_a0", 24'h125001, log_q[0][39:16]);
    chk("g_a1", 24'h341006, log_q[1][39:16]);
    chk("g_a2", 24'h125002, log_q[2][39:16]);
  endtask : t_wait

  initial begin
    #4000000;
    $display("[FAIL] watchdog expected finish seen timeout");
    failures++;
    end_sim();
  end

  initial begin
    repeat (8) @(negedge clk_i);
    chk("rst_n", 2'h0, queue_count_o);
    chk("rst_stk", 0, stack_bank_sel_o);
    chk("rst_ram", 0, ram_area_sel_o);
    nrst_i = 1;
    t_fetch();
    t_odd_narrow();
    t_stall_rel();
    t_reads();
    t_writes();
    t_wait();
    end_sim();
  end
endmodule : prefetch_bus_interface_test

// ===== verilog/area_decode.sv
module area_decode
  import gateway_pkg::*;
(
  input wire logic [23:0] addr_i,
  input wire logic ram_sel_i,
  output logic periph_hit_o,
  output logic ram_hit_o,
  output logic [8:0] ram_index_o
);
  logic bank0;
  logic [15:0] off;
  logic [15:0] rel;

  assign bank0 = addr_i[23:16] == BANK0;
  assign off = addr_i[15:0];
  assign rel = off - RAM_BEG;
  // peripheral registers at the bottom of bank 0 and just below 2000
  assign periph_hit_o = bank0 && (off <= PERIPH_LO_END
    || (off >= PERIPH_HI_BEG && off <= PERIPH_HI_END));
  // upper half of the ram only when selected
  assign ram_hit_o = bank0 && off >= RAM_BEG
    && (off <= RAM_LOW_END || (ram_sel_i && off <= RAM_END));
  assign ram_index_o = rel[9:1];
endmodule : area_decode

// ===== verilog/gateway_pkg.sv
package gateway_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int BUS_PERIOD_NS = 200;
  localparam int BUS_DIV = (BUS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] BUS_DIV_LAST = 2'(BUS_DIV - 1);
  localparam logic [1:0] QUEUE_DEPTH = 2'h3;
  localparam logic [1:0] PREFETCH_LEVEL = 2'h1;
  localparam logic [7:0] BANK0 = 8'h00;
  localparam logic [7:0] STACK_HI_BANK = 8'hFF;
  localparam logic [15:0] PERIPH_LO_END = 16'h007F;
  localparam logic [15:0] PERIPH_HI_BEG = 16'h1FC0;
  localparam logic [15:0] PERIPH_HI_END = 16'h1FFF;
  localparam logic [15:0] RAM_BEG = 16'h0080;
  localparam logic [15:0] RAM_LOW_END = 16'h027F;
  localparam logic [15:0] RAM_END = 16'h047F;
  localparam int RAM_WORDS = 512;
  localparam logic [15:0] MODE_REG0_ADDR = 16'h005E;
  localparam logic [15:0] MODE_REG1_ADDR = 16'h005F;
  localparam int STACK_SEL_BIT = 7;
  localparam int RAM_SEL_BIT = 1;
  localparam logic STACK_SEL_RESET = 1'b0;
  localparam logic RAM_SEL_RESET = 1'b0;
  localparam logic [1:0] LANES_BOTH = 2'h3;
  localparam logic [1:0] LANE_EVEN = 2'h1;
  localparam logic [1:0] LANE_ODD = 2'h2;

  typedef enum logic [1:0] {
    MODE_DATA,
    MODE_DIRECT,
    MODE_STACK
  } addr_mode_t;

  typedef enum {
    ST_IDLE,
    ST_FETCH,
    ST_DATA_LO,
    ST_DATA_HI
  } bus_state_t;
endpackage : gateway_pkg

// ===== verilog/internal_ram.sv
module internal_ram
  import gateway_pkg::*;
(
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [1:0] be_i,
  input wire logic [8:0] index_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [RAM_WORDS];

  always_ff @(posedge clk_i) begin
    if (we_i && be_i[0]) begin
      mem[index_i][7:0] <= wdata_i[7:0];
    end
    if (we_i && be_i[1]) begin
      mem[index_i][15:8] <= wdata_i[15:8];
    end
  end

  assign rdata_o = mem[index_i];
endmodule : internal_ram

// ===== verilog/prefetch_bus_interface.sv
module prefetch_bus_interface
  import gateway_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic narrow_bus_i,
  input wire logic take_i,
  input wire logic [1:0] take_count_i,
  input wire logic jump_i,
  input wire logic [23:0] jump_target_i,
  input wire logic rel_jump_i,
  input wire logic [15:0] rel_offset_i,
  input wire logic data_req_i,
  input wire logic data_we_i,
  input wire logic [1:0] addr_mode_i,
  input wire logic [15:0] data_offset_i,
  input wire logic [15:0] data_wdata_i,
  input wire logic data_length_flag_i,
  input wire logic index_length_flag_i,
  input wire logic use_index_i,
  input wire logic [7:0] data_bank_select_i,
  input wire logic [15:0] zero_page_base_i,
  input wire logic [15:0] bus_rdata_i,
  output logic cpu_run_o,
  output logic [23:0] queue_bytes_o,
  output logic [1:0] queue_count_o,
  output logic [7:0] code_bank_register_o,
  output logic [15:0] program_counter_o,
  output logic [15:0] data_rdata_o,
  output logic [23:0] bus_addr_o,
  output logic bus_rd_o,
  output logic bus_wr_o,
  output logic [1:0] bus_be_o,
  output logic [15:0] bus_wdata_o,
  output logic bus_internal_o,
  output logic stack_bank_sel_o,
  output logic ram_area_sel_o
);
  logic [1:0] div_cnt, next_div_cnt;
  logic tick;
  bus_state_t state, next_state;
  logic [23:0] fetch_addr, next_fetch_addr, cpu_pc, next_cpu_pc;
  logic [7:0] q [3];
  logic [7:0] sq [3];
  logic [7:0] next_q [3];
  logic [1:0] count, scnt, next_count, app_n;
  logic [7:0] app_b0, app_b1;
  logic drop, next_drop;
  logic pend, next_pend, pend_we, next_pend_we, pend_wide, next_pend_wide;
  logic [23:0] pend_addr, next_pend_addr;
  logic [15:0] pend_wdata, next_pend_wdata, dbuf, next_dbuf;
  logic rd_valid, next_rd_valid, stack_sel, next_stack_sel, ram_sel, next_ram_sel;
  logic [23:0] next_bus_addr;
  logic next_bus_rd, next_bus_wr;
  logic [1:0] next_bus_be;
  logic [15:0] next_bus_wdata;
  logic [23:0] req_addr;
  logic req_wide, fetch_busy, write_take, read_latch, read_take, starve, take_eff;
  logic jump_now;
  logic [23:0] jump_dest;
  logic periph_hit, ram_hit, ram_we;
  logic [8:0] ram_index;
  logic [15:0] ram_rdata, rdata;

  area_decode u_decode (
    .addr_i(bus_addr_o),
    .ram_sel_i(ram_sel),
    .periph_hit_o(periph_hit),
    .ram_hit_o(ram_hit),
    .ram_index_o(ram_index)
  );

  internal_ram u_ram (
    .clk_i(clk_i),
    .we_i(ram_we),
    .be_i(bus_be_o),
    .index_i(ram_index),
    .wdata_i(bus_wdata_o),
    .rdata_o(ram_rdata)
  );

  // bus cycle strobe: one tick every BUS_DIV clocks
  assign tick = div_cnt == BUS_DIV_LAST;
  assign next_div_cnt = tick ? 2'h0 : div_cnt + 2'h1;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // data address formation
  always_comb begin
    case (addr_mode_t'(addr_mode_i))
      MODE_DIRECT: req_addr = {BANK0, zero_page_base_i + {8'h00, data_offset_i[7:0]}};
      MODE_STACK: req_addr = {stack_sel ? STACK_HI_BANK : BANK0, data_offset_i};
      default: req_addr = {data_bank_select_i, data_offset_i};
    endcase
  end
  assign req_wide = !(use_index_i ? index_length_flag_i : data_length_flag_i);

  // core side handshake and clock stretch
  assign fetch_busy = state == ST_FETCH;
  assign write_take = data_req_i && data_we_i && !pend && !fetch_busy;
  assign read_latch = data_req_i && !data_we_i && !pend && !fetch_busy && !rd_valid;
  assign read_take = data_req_i && !data_we_i && rd_valid;
  assign starve = take_i && (count < take_count_i);
  assign cpu_run_o = !starve && !(data_req_i && !(write_take || read_take));
  assign take_eff = take_i && cpu_run_o;
  assign jump_now = (jump_i || rel_jump_i) && cpu_run_o;
  assign jump_dest = jump_i ? jump_target_i
    : cpu_pc + {{8{rel_offset_i[15]}}, rel_offset_i};
  assign rdata = ram_hit ? ram_rdata : bus_rdata_i;
  assign ram_we = tick && bus_wr_o && ram_hit;

  // queue after consumption
  always_comb begin
    scnt = take_eff ? count - take_count_i : count;
    for (int i = 0; i < 3; i++) begin
      sq[i] = 8'h00;
      if (!take_eff) begin
        sq[i] = q[i];
      end else if (i + int'(take_count_i) < 3) begin
        sq[i] = q[i + int'(take_count_i)];
      end
    end
    next_cpu_pc = cpu_pc;
    if (jump_now) begin
      next_cpu_pc = jump_dest;
    end else if (take_eff) begin
      next_cpu_pc = cpu_pc + {22'h0, take_count_i};
    end
  end

  // bus sequencer
  always_comb begin
    next_state = state;
    next_fetch_addr = jump_now ? jump_dest : fetch_addr;
    next_drop = jump_now ? 1'b1 : drop;
    next_pend = pend;
    next_pend_we = pend_we;
    next_pend_wide = pend_wide;
    next_pend_addr = pend_addr;
    next_pend_wdata = pend_wdata;
    next_dbuf = dbuf;
    next_rd_valid = read_take ? 1'b0 : rd_valid;
    next_stack_sel = stack_sel;
    next_ram_sel = ram_sel;
    next_bus_addr = bus_addr_o;
    next_bus_rd = bus_rd_o;
    next_bus_wr = bus_wr_o;
    next_bus_be = bus_be_o;
    next_bus_wdata = bus_wdata_o;
    app_n = 2'h0;
    app_b0 = 8'h00;
    app_b1 = 8'h00;
    if (write_take || read_latch) begin
      next_pend = 1'b1;
      next_pend_we = data_we_i;
      next_pend_wide = req_wide;
      next_pend_addr = req_addr;
      next_pend_wdata = data_wdata_i;
    end
    if (tick) begin
      case (state)
        ST_FETCH: begin
          if (!drop && !jump_now) begin
            if (bus_be_o == LANE_ODD) begin
              app_n = 2'h1;
              app_b0 = rdata[15:8];
            end else if (bus_be_o == LANES_BOTH) begin
              app_n = 2'h2;
              app_b0 = rdata[7:0];
              app_b1 = rdata[15:8];
            end else begin
              app_n = 2'h1;
              app_b0 = rdata[7:0];
            end
          end
          next_state = ST_IDLE;
        end
        ST_DATA_LO: begin
          if (pend_wide && pend_addr[0]) begin
            next_dbuf[7:0] = rdata[15:8];
            next_state = ST_DATA_HI;
          end else begin
            if (pend_wide) begin
              next_dbuf = rdata;
            end else begin
              next_dbuf = {8'h00, pend_addr[0] ? rdata[15:8] : rdata[7:0]};
            end
            next_state = ST_IDLE;
          end
        end
        ST_DATA_HI: begin
          next_dbuf[15:8] = rdata[7:0];
          next_state = ST_IDLE;
        end
        default: next_state = ST_IDLE;
      endcase
      if (bus_wr_o && bus_addr_o[23:1] == {BANK0, MODE_REG0_ADDR[15:1]}) begin
        if (bus_be_o[0]) begin
          next_stack_sel = bus_wdata_o[STACK_SEL_BIT];
        end
        if (bus_be_o[1]) begin
          next_ram_sel = bus_wdata_o[8 + RAM_SEL_BIT];
        end
      end
      if ((state == ST_DATA_LO || state == ST_DATA_HI) && next_state == ST_IDLE) begin
        next_pend = 1'b0;
        next_rd_valid = !pend_we;
      end
      next_bus_rd = 1'b0;
      next_bus_wr = 1'b0;
      next_bus_be = 2'h0;
      if (next_state == ST_DATA_HI) begin
        next_bus_addr = bus_addr_o + 24'h1;
        next_bus_rd = !pend_we;
        next_bus_wr = pend_we;
        next_bus_be = LANE_EVEN;
        next_bus_wdata = {8'h00, pend_wdata[15:8]};
      end else if (next_pend && !(next_rd_valid && !read_take)) begin
        next_state = ST_DATA_LO;
        next_bus_addr = next_pend_addr;
        next_bus_rd = !next_pend_we;
        next_bus_wr = next_pend_we;
        if (next_pend_wide && !next_pend_addr[0]) begin
          next_bus_be = LANES_BOTH;
          next_bus_wdata = next_pend_wdata;
        end else if (next_pend_addr[0]) begin
          next_bus_be = LANE_ODD;
          next_bus_wdata = {next_pend_wdata[7:0], 8'h00};
        end else begin
          next_bus_be = LANE_EVEN;
          next_bus_wdata = {8'h00, next_pend_wdata[7:0]};
        end
      end else if ((scnt + app_n <= PREFETCH_LEVEL || (take_i && scnt + app_n < take_count_i))
        && !data_req_i) begin
        // a starved core also gets a fetch, one byte when two are queued
        next_state = ST_FETCH;
        next_drop = 1'b0;
        next_bus_addr = next_fetch_addr;
        next_bus_rd = 1'b1;
        if (next_fetch_addr[0]) begin
          next_bus_be = LANE_ODD;
          next_fetch_addr = next_fetch_addr + 24'h1;
        end else if (narrow_bus_i || scnt + app_n > PREFETCH_LEVEL) begin
          next_bus_be = LANE_EVEN;
          next_fetch_addr = next_fetch_addr + 24'h1;
        end else begin
          next_bus_be = LANES_BOTH;
          next_fetch_addr = next_fetch_addr + 24'h2;
        end
      end
    end
  end

  // queue append after consumption
  always_comb begin
    next_q = sq;
    next_count = scnt + app_n;
    if (jump_now) begin
      next_count = 2'h0;
    end else begin
      if (app_n != 2'h0) begin
        next_q[scnt] = app_b0;
      end
      if (app_n == 2'h2) begin
        next_q[scnt + 2'h1] = app_b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
      fetch_addr <= 24'h0;
      cpu_pc <= 24'h0;
      q <= '{8'h00, 8'h00, 8'h00};
      count <= 2'h0;
      drop <= 1'b0;
      pend <= 1'b0;
      pend_we <= 1'b0;
      pend_wide <= 1'b0;
      pend_addr <= 24'h0;
      pend_wdata <= 16'h0;
      dbuf <= 16'h0;
      rd_valid <= 1'b0;
      stack_sel <= STACK_SEL_RESET;
      ram_sel <= RAM_SEL_RESET;
      bus_addr_o <= 24'h0;
      bus_rd_o <= 1'b0;
      bus_wr_o <= 1'b0;
      bus_be_o <= 2'h0;
      bus_wdata_o <= 16'h0;
    end else begin
      state <= next_state;
      fetch_addr <= next_fetch_addr;
      cpu_pc <= next_cpu_pc;
      q <= next_q;
      count <= next_count;
      drop <= next_drop;
      pend <= next_pend;
      pend_we <= next_pend_we;
      pend_wide <= next_pend_wide;
      pend_addr <= next_pend_addr;
      pend_wdata <= next_pend_wdata;
      dbuf <= next_dbuf;
      rd_valid <= next_rd_valid;
      stack_sel <= next_stack_sel;
      ram_sel <= next_ram_sel;
      bus_addr_o <= next_bus_addr;
      bus_rd_o <= next_bus_rd;
      bus_wr_o <= next_bus_wr;
      bus_be_o <= next_bus_be;
      bus_wdata_o <= next_bus_wdata;
    end
  end

  assign queue_bytes_o = {q[2], q[1], q[0]};
  assign queue_count_o = count;
  assign code_bank_register_o = cpu_pc[23:16];
  assign program_counter_o = cpu_pc[15:0];
  assign data_rdata_o = dbuf;
  assign bus_internal_o = periph_hit || ram_hit;
  assign stack_bank_sel_o = stack_sel;
  assign ram_area_sel_o = ram_sel;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_NO_FETCH_WHILE_PEND: assert property (
    tick && ((pend && state == ST_IDLE) || data_req_i) |=> state != ST_FETCH)
    else $error("prefetch started over a waiting data access");
  AST_PREFETCH_START: assert property (
    tick && state == ST_IDLE && !pend && !data_req_i
    && count == 2'h0 && !take_i && !jump_i && !rel_jump_i |=> state == ST_FETCH)
    else $error("empty queue did not start a prefetch");
  AST_QUEUE_MAX: assert property (
    state == ST_FETCH |-> {1'b0, count} + (bus_be_o == LANES_BOTH ? 3'h2 : 3'h1)
    <= {1'b0, QUEUE_DEPTH})
    else $error("prefetch could overfill the queue");
  AST_FLUSH: assert property (jump_i && cpu_run_o |=> count == 2'h0
    && cpu_pc == $past(jump_target_i))
    else $error("jump did not flush queue");
  AST_STARVE: assert property (take_i && count < take_count_i |-> !cpu_run_o)
    else $error("core ran on a starved queue");
  AST_FETCH_WAIT: assert property (data_req_i && fetch_busy && !rd_valid |-> !cpu_run_o)
    else $error("data access not held during prefetch");
  AST_POSTED: assert property (
    data_req_i && data_we_i && !pend && !fetch_busy && !take_i |-> cpu_run_o ##1 pend)
    else $error("write not posted");
  AST_SPLIT: assert property (
    tick && state == ST_DATA_LO && pend_wide && pend_addr[0]
    |=> state == ST_DATA_HI && bus_be_o == LANE_EVEN
    && bus_addr_o == $past(bus_addr_o) + 24'h1)
    else $error("odd word not split low byte first");
  AST_EVEN_WORD: assert property (state == ST_DATA_LO && pend_wide && !pend_addr[0]
    |-> bus_be_o == LANES_BOTH)
    else $error("even word not one cycle");
  AST_BUS_PERIOD: assert property (tick |=> !tick)
    else $error("bus strobe faster than two clocks");

  COV_FETCH_TWO: cover property (tick && state == ST_FETCH && bus_be_o == LANES_BOTH);
  COV_SPLIT_READ: cover property (state == ST_DATA_HI && bus_rd_o);
  COV_POSTED_WRITE: cover property (write_take && cpu_run_o);
  COV_STALL: cover property (starve ##[1:20] cpu_run_o);
endmodule : prefetch_bus_interface
